// ===== dtt_pkg.sv
// Constants and types shared by the debug trace and trigger register logic.
`default_nettype none
package dtt_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int TRACE_DEPTH = 8;
   localparam int BUF_DEPTH = 16;
   localparam int IDX_W = 4;
   localparam int COUNT_W = 4;

   localparam logic [IDX_W-1:0] IDX_FORCE_RESET = 4'h0;
   localparam logic [IDX_W-1:0] IDX_CMP_A_HIGH = 4'h1;
   localparam logic [IDX_W-1:0] IDX_CMP_A_LOW = 4'h2;
   localparam logic [IDX_W-1:0] IDX_CMP_B_HIGH = 4'h3;
   localparam logic [IDX_W-1:0] IDX_CMP_B_LOW = 4'h4;
   localparam logic [IDX_W-1:0] IDX_FIFO_HIGH = 4'h5;
   localparam logic [IDX_W-1:0] IDX_FIFO_LOW = 4'h6;
   localparam logic [IDX_W-1:0] IDX_CONTROL = 4'h7;

   localparam int BIT_ENABLE = 7;
   localparam int BIT_ARM = 6;
   localparam int BIT_TAG = 5;
   localparam int BIT_BREAK = 4;
   localparam int BIT_RWA = 3;
   localparam int BIT_RWA_EN = 2;
   localparam int BIT_RWB = 1;
   localparam int BIT_RWB_EN = 0;
   localparam int BIT_FORCE_RESET = 0;

   localparam logic [ADDR_W-1:0] CMP_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
   localparam logic [COUNT_W-1:0] TRACE_FULL = 4'h8;

   typedef enum logic [3:0] {
      TRG_A_ONLY = 4'h0,
      TRG_A_OR_B = 4'h1,
      TRG_A_THEN_B = 4'h2,
      TRG_EVENT_B = 4'h3,
      TRG_A_THEN_EVENT_B = 4'h4,
      TRG_A_AND_B_DATA = 4'h5,
      TRG_A_AND_NOT_B_DATA = 4'h6,
      TRG_INSIDE = 4'h7,
      TRG_OUTSIDE = 4'h8
   } dtt_trig_t;

   typedef enum logic [1:0] {
      RUN_IDLE = 2'h0,
      RUN_WAIT = 2'h1,
      RUN_STORE = 2'h3
   } dtt_run_t;
endpackage
`default_nettype wire

// ===== dtt_trace_regs.sv
// Stream FIFO and the debug comparator, trace FIFO and control register block.
`default_nettype none
module dtt_stream_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   input wire logic flush,
   // Filling side.
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] FULL_LEVEL = (PTR_W + 1)'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W:0] level;
   } dtt_fifo_state_t;
   dtt_fifo_state_t st;
   dtt_fifo_state_t next_st;
   logic push;
   logic pop;

   assign inReady = st.level != FULL_LEVEL;
   assign outValid = st.level != '0;
   assign outData = st.mem[st.rdPtr];

   always_comb begin
      next_st = st;
      push = inValid && inReady;
      pop = outValid && outReady;
      if (push) begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = st.wrPtr + 1'b1;
      end
      if (pop) begin
         next_st.rdPtr = st.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         next_st.level = st.level + 1'b1;
      end else if (pop && !push) begin
         next_st.level = st.level - 1'b1;
      end
      if (flush) begin
         next_st.wrPtr = '0;
         next_st.rdPtr = '0;
         next_st.level = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

module dtt_trace_regs (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Register access port.
   input wire logic regRead,
   input wire logic regWrite,
   input wire logic bdmAccess,
   input wire logic [dtt_pkg::IDX_W-1:0] regIndex,
   input wire logic [dtt_pkg::DATA_W-1:0] regWriteData,
   output logic [dtt_pkg::DATA_W-1:0] regReadData,
   // CPU bus observation.
   input wire logic cpuCycle,
   input wire logic cpuRead,
   input wire logic cpuFetch,
   input wire logic [dtt_pkg::ADDR_W-1:0] cpuAddr,
   input wire logic [dtt_pkg::DATA_W-1:0] cpuData,
   input wire logic cpuExec,
   input wire logic [dtt_pkg::ADDR_W-1:0] cpuExecAddr,
   // Trigger setup and chip state.
   input wire logic [3:0] triggerModeCode,
   input wire logic beginTrace,
   input wire logic executionQualifiedTrigger,
   input wire logic chipSecure,
   // Outputs to CPU and system.
   output logic breakRequest,
   output logic breakTag,
   output logic systemResetRequest,
   output logic runActiveFlag,
   output logic [dtt_pkg::COUNT_W-1:0] traceValidCount
);
   import dtt_pkg::*;

   typedef struct packed {
      logic [ADDR_W-1:0] cmpA;
      logic [ADDR_W-1:0] cmpB;
      logic [DATA_W-1:0] control;
      dtt_run_t run;
      logic aSeen;
      logic [COUNT_W-1:0] count;
      logic [TRACE_DEPTH-1:0][ADDR_W-1:0] trace;
      logic [ADDR_W-1:0] lastFetch;
      logic [DATA_W-1:0] readData;
      logic breakReq;
      logic breakType;
      logic forceReset;
   } dtt_state_t;

   dtt_state_t st;
   dtt_state_t next_st;
   logic [ADDR_W-1:0] tapAddr;
   logic tapValid;
   logic tapRead;
   logic aHit;
   logic bHit;
   logic armed;
   logic trigger;
   logic eventMode;
   logic beginRun;
   logic lowRead;
   logic startRun;
   logic capValid;
   logic [ADDR_W-1:0] capWord;
   logic bufInReady;
   logic bufOutValid;
   logic bufOutReady;
   logic [ADDR_W-1:0] bufOutData;
   logic drain;
   logic enableNew;
   logic armNew;
   logic runDone;

   function automatic logic cmpHit(input logic [ADDR_W-1:0] value, input logic [ADDR_W-1:0] addr,
                                   input logic valid, input logic qualify, input logic dir,
                                   input logic rd);
      cmpHit = valid && (addr == value) && (!qualify || (dir == rd));
   endfunction

   function automatic logic isEventMode(input logic [3:0] mode);
      isEventMode = (mode == TRG_EVENT_B) || (mode == TRG_A_THEN_EVENT_B);
   endfunction

   function automatic logic [TRACE_DEPTH-1:0][ADDR_W-1:0] shiftIn(
         input logic [TRACE_DEPTH-1:0][ADDR_W-1:0] trace, input logic [ADDR_W-1:0] word);
      shiftIn = {word, trace[TRACE_DEPTH-1:1]};
   endfunction

   dtt_stream_fifo #(.WIDTH(ADDR_W), .DEPTH(BUF_DEPTH)) captureBuffer (
      .clock(clock),
      .reset(reset),
      .flush(startRun),
      .inValid(capValid && st.run == RUN_STORE),
      .inReady(bufInReady),
      .inData(capWord),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   assign regReadData = st.readData;
   assign breakRequest = st.breakReq;
   assign breakTag = st.breakType;
   assign systemResetRequest = st.forceReset;
   assign runActiveFlag = st.control[BIT_ARM];
   assign traceValidCount = st.count;

   always_comb begin
      tapAddr = executionQualifiedTrigger ? cpuExecAddr : cpuAddr;
      tapValid = executionQualifiedTrigger ? cpuExec : cpuCycle;
      tapRead = executionQualifiedTrigger ? 1'b1 : cpuRead;
      aHit = cmpHit(st.cmpA, tapAddr, tapValid, st.control[BIT_RWA_EN],
                    st.control[BIT_RWA], tapRead);
      bHit = cmpHit(st.cmpB, tapAddr, tapValid, st.control[BIT_RWB_EN],
                    st.control[BIT_RWB], tapRead);
      armed = st.run != RUN_IDLE;
      eventMode = isEventMode(triggerModeCode);
      beginRun = beginTrace || eventMode;
      case (triggerModeCode)
         TRG_A_ONLY: trigger = aHit;
         TRG_A_OR_B: trigger = aHit || bHit;
         TRG_A_THEN_B: trigger = st.aSeen && bHit;
         TRG_EVENT_B: trigger = bHit;
         TRG_A_THEN_EVENT_B: trigger = st.aSeen && bHit;
         TRG_A_AND_B_DATA: trigger = aHit && (cpuData == st.cmpB[DATA_W-1:0]);
         TRG_A_AND_NOT_B_DATA: trigger = aHit && (cpuData != st.cmpB[DATA_W-1:0]);
         TRG_INSIDE: trigger = tapValid && tapAddr >= st.cmpA && tapAddr <= st.cmpB;
         TRG_OUTSIDE: trigger = tapValid && (tapAddr < st.cmpA || tapAddr > st.cmpB);
         default: trigger = 1'b0;
      endcase
      trigger = trigger && armed;
      capWord = eventMode ? {READ_ZERO, cpuData} : cpuAddr;
      capValid = eventMode ? trigger : cpuFetch;
      lowRead = regRead && regIndex == IDX_FIFO_LOW;
      bufOutReady = !lowRead && !(beginRun && st.count == TRACE_FULL);
      drain = bufOutValid && bufOutReady;
      runDone = beginRun ? (drain && st.count == TRACE_FULL - 1'b1) : trigger;
      runDone = runDone && st.run == RUN_STORE;
      enableNew = regWriteData[BIT_ENABLE] && !chipSecure;
      armNew = regWriteData[BIT_ARM] && enableNew;
      startRun = regWrite && regIndex == IDX_CONTROL && armNew &&
                 (!st.control[BIT_ARM] || runDone);

      next_st = st;
      next_st.breakReq = 1'b0;
      next_st.forceReset = 1'b0;
      if (cpuFetch) begin
         next_st.lastFetch = cpuAddr;
      end
      if (armed && aHit) begin
         next_st.aSeen = 1'b1;
      end
      if (drain) begin
         next_st.trace = shiftIn(st.trace, bufOutData);
         if (st.count != TRACE_FULL) begin
            next_st.count = st.count + 1'b1;
         end
      end
      case (st.run)
         RUN_WAIT: begin
            if (trigger) begin
               next_st.run = RUN_STORE;
            end
         end
         RUN_STORE: begin
            if (runDone) begin
               next_st.run = RUN_IDLE;
               next_st.control[BIT_ARM] = 1'b0;
               next_st.breakReq = st.control[BIT_BREAK];
               next_st.breakType = st.control[BIT_TAG];
            end
         end
         default: begin
         end
      endcase

      if (regRead) begin
         if (regIndex == IDX_FORCE_RESET) begin
            next_st.readData = READ_ZERO;
         end else if (regIndex == IDX_CMP_A_HIGH) begin
            next_st.readData = st.cmpA[ADDR_W-1:DATA_W];
         end else if (regIndex == IDX_CMP_A_LOW) begin
            next_st.readData = st.cmpA[DATA_W-1:0];
         end else if (regIndex == IDX_CMP_B_HIGH) begin
            next_st.readData = st.cmpB[ADDR_W-1:DATA_W];
         end else if (regIndex == IDX_CMP_B_LOW) begin
            next_st.readData = st.cmpB[DATA_W-1:0];
         end else if (regIndex == IDX_FIFO_HIGH) begin
            next_st.readData = eventMode ? READ_ZERO : st.trace[0][ADDR_W-1:DATA_W];
         end else if (regIndex == IDX_FIFO_LOW) begin
            next_st.readData = st.trace[0][DATA_W-1:0];
         end else if (regIndex == IDX_CONTROL) begin
            next_st.readData = st.control;
         end else begin
            next_st.readData = READ_ZERO;
         end
      end
      if (lowRead && !st.control[BIT_ARM]) begin
         next_st.trace = shiftIn(st.trace, st.lastFetch);
      end

      if (regWrite) begin
         if (regIndex == IDX_FORCE_RESET) begin
            next_st.forceReset = bdmAccess && regWriteData[BIT_FORCE_RESET];
         end else if (regIndex == IDX_CMP_A_HIGH && !st.control[BIT_ARM]) begin
            next_st.cmpA[ADDR_W-1:DATA_W] = regWriteData;
         end else if (regIndex == IDX_CMP_A_LOW && !st.control[BIT_ARM]) begin
            next_st.cmpA[DATA_W-1:0] = regWriteData;
         end else if (regIndex == IDX_CMP_B_HIGH && !st.control[BIT_ARM]) begin
            next_st.cmpB[ADDR_W-1:DATA_W] = regWriteData;
         end else if (regIndex == IDX_CMP_B_LOW && !st.control[BIT_ARM]) begin
            next_st.cmpB[DATA_W-1:0] = regWriteData;
         end else if (regIndex == IDX_CONTROL) begin
            next_st.control = {enableNew, armNew, regWriteData[BIT_TAG:0]};
            if (startRun) begin
               next_st.run = (beginTrace && !eventMode) ? RUN_WAIT : RUN_STORE;
               next_st.count = COUNT_RESET;
               next_st.aSeen = 1'b0;
            end else if (!armNew) begin
               next_st.run = RUN_IDLE;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st <= '{cmpA: CMP_RESET, cmpB: CMP_RESET, control: CONTROL_RESET, run: RUN_IDLE,
                 count: COUNT_RESET, readData: READ_ZERO, default: '0};
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence sUserForce;
      regWrite && !bdmAccess && regIndex == IDX_FORCE_RESET;
   endsequence

   sequence sBdmForce;
      regWrite && bdmAccess && regIndex == IDX_FORCE_RESET && regWriteData[BIT_FORCE_RESET];
   endsequence

   sequence sArmWrite;
      regWrite && regIndex == IDX_CONTROL && regWriteData[BIT_ARM] &&
         regWriteData[BIT_ENABLE] && !chipSecure && !st.control[BIT_ARM];
   endsequence

   a_user_force_ignored:
      assert property (sUserForce |=> !systemResetRequest)
      else $error("User write to force-reset register caused a reset request.");

   a_force_read_zero:
      assert property (regRead && regIndex == IDX_FORCE_RESET |=> regReadData == READ_ZERO)
      else $error("Force-reset register read was not zero.");

   a_force_reset_pulse:
      assert property (sBdmForce ##1 !(regWrite && regIndex == IDX_FORCE_RESET)
                       |-> systemResetRequest ##1 !systemResetRequest)
      else $error("Background force-reset write did not give a one-cycle reset request.");

   a_cmp_write_locked:
      assert property (regWrite && st.control[BIT_ARM] && regIndex >= IDX_CMP_A_HIGH &&
                       regIndex <= IDX_CMP_B_LOW |=> $stable(st.cmpA) && $stable(st.cmpB))
      else $error("Comparator byte changed while armed.");

   a_event_high_zero:
      assert property (regRead && regIndex == IDX_FIFO_HIGH && isEventMode(triggerModeCode)
                       |=> regReadData == READ_ZERO)
      else $error("Trace high byte not zero in event-only mode.");

   a_high_read_hold:
      assert property (regRead && regIndex == IDX_FIFO_HIGH && !bufOutValid
                       |=> $stable(st.trace))
      else $error("Trace high byte read moved the FIFO.");

   a_armed_no_advance:
      assert property (lowRead && st.control[BIT_ARM] && !bufOutValid |=> $stable(st.trace))
      else $error("Low byte read advanced the FIFO while armed.");

   a_profile_load:
      assert property (lowRead && !st.control[BIT_ARM]
                       |=> st.trace[TRACE_DEPTH-1] == $past(st.lastFetch))
      else $error("Unarmed low byte read did not load the last fetch address.");

   a_secure_enable:
      assert property (regWrite && regIndex == IDX_CONTROL && chipSecure
                       |=> !st.control[BIT_ENABLE])
      else $error("Enable bit set while secured.");

   a_run_start:
      assert property (sArmWrite |=> runActiveFlag && traceValidCount == COUNT_RESET)
      else $error("Arm write did not start a clean run.");

   a_end_trace_break:
      assert property (st.run == RUN_STORE && !beginRun && trigger && st.control[BIT_BREAK] &&
                       !regWrite |=> breakRequest && !runActiveFlag ##1 !breakRequest)
      else $error("End trace trigger did not end the run with one break request.");
endmodule
`default_nettype wire

// ===== dtt_cpu_model.sv
// CPU core model that drives the observed bus cycles seen by the debug block.
`default_nettype none
module dtt_cpu_model (
   // Clock.
   input wire logic clock,
   // Observed CPU bus.
   output logic cpuCycle,
   output logic cpuRead,
   output logic cpuFetch,
   output logic [dtt_pkg::ADDR_W-1:0] cpuAddr,
   output logic [dtt_pkg::DATA_W-1:0] cpuData,
   // Opcode tracking result.
   output logic cpuExec,
   output logic [dtt_pkg::ADDR_W-1:0] cpuExecAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   import dtt_pkg::*;

   initial begin
      cpuCycle = 1'b0;
      cpuRead = 1'b1;
      cpuFetch = 1'b0;
      cpuAddr = 16'hFFFF;
      cpuData = 8'hFF;
      cpuExec = 1'b0;
      cpuExecAddr = 16'hFFFF;
   end

   // One bus cycle; afterwards address, data and direction show the inverse and cycle and fetch drop, so stale values never match.
   task automatic busCycle(input logic [ADDR_W-1:0] addr, input logic rd, input logic fetch,
                           input logic [DATA_W-1:0] data);
      @(posedge clock);
      cpuCycle <= 1'b1;
      cpuRead <= rd;
      cpuFetch <= fetch;
      cpuAddr <= addr;
      cpuData <= data;
      @(posedge clock);
      cpuCycle <= 1'b0;
      cpuFetch <= 1'b0;
      cpuRead <= ~rd;
      cpuAddr <= ~addr;
      cpuData <= ~data;
   endtask

   // One executed opcode as reported by the opcode tracking logic.
   task automatic execCycle(input logic [ADDR_W-1:0] addr);
      @(posedge clock);
      cpuExec <= 1'b1;
      cpuExecAddr <= addr;
      @(posedge clock);
      cpuExec <= 1'b0;
      cpuExecAddr <= ~addr;
   endtask
endmodule
`default_nettype wire

// ===== dtt_trace_regs_bench.sv
// Self-checking bench for the debug comparator, trace and control registers.
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failCount++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module dtt_trace_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dtt_pkg::*;

   logic clock, reset, regRead, regWrite, bdmAccess;
   logic [IDX_W-1:0] regIndex;
   logic [DATA_W-1:0] regWriteData, regReadData, cpuData;
   logic cpuCycle, cpuRead, cpuFetch, cpuExec;
   logic [ADDR_W-1:0] cpuAddr, cpuExecAddr;
   logic [3:0] triggerModeCode;
   logic beginTrace, executionQualifiedTrigger, chipSecure;
   logic breakRequest, breakTag, systemResetRequest, runActiveFlag;
   logic [COUNT_W-1:0] traceValidCount;
   int failCount = 0;
   int numChecks = 0;

   dtt_trace_regs uut (.clock(clock), .reset(reset), .regRead(regRead), .regWrite(regWrite),
      .bdmAccess(bdmAccess), .regIndex(regIndex), .regWriteData(regWriteData),
      .regReadData(regReadData), .cpuCycle(cpuCycle), .cpuRead(cpuRead), .cpuFetch(cpuFetch),
      .cpuAddr(cpuAddr), .cpuData(cpuData), .cpuExec(cpuExec), .cpuExecAddr(cpuExecAddr),
      .triggerModeCode(triggerModeCode), .beginTrace(beginTrace),
      .executionQualifiedTrigger(executionQualifiedTrigger), .chipSecure(chipSecure),
      .breakRequest(breakRequest), .breakTag(breakTag),
      .systemResetRequest(systemResetRequest), .runActiveFlag(runActiveFlag),
      .traceValidCount(traceValidCount));

   dtt_cpu_model cpu (.clock(clock), .cpuCycle(cpuCycle), .cpuRead(cpuRead),
      .cpuFetch(cpuFetch), .cpuAddr(cpuAddr), .cpuData(cpuData), .cpuExec(cpuExec),
      .cpuExecAddr(cpuExecAddr));

   always #25 clock = ~clock;

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data,
                     input logic bdm);
      @(posedge clock);
      regWrite <= 1'b1;
      regIndex <= idx;
      regWriteData <= data;
      bdmAccess <= bdm;
      @(posedge clock);
      regWrite <= 1'b0;
      bdmAccess <= 1'b0;
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] data);
      @(posedge clock);
      regRead <= 1'b1;
      regIndex <= idx;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      data = regReadData;
   endtask

   task automatic expectReg(input string nm, input logic [IDX_W-1:0] idx,
                            input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] got;
      rd(idx, got);
      `CHK(nm, exp, got)
   endtask

   task automatic waitBreak(output logic seen, output logic tagSeen);
      seen = 1'b0;
      tagSeen = 1'b0;
      repeat (10) begin
         #1;
         if (breakRequest === 1'b1) begin
            seen = 1'b1;
            tagSeen = breakTag;
         end
         @(posedge clock);
      end
   endtask

   task automatic reportAndStop();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      failCount++;
      reportAndStop();
   end

   initial begin
      logic seen, tagSeen;
      logic [15:0] w;
      logic [7:0] cmpVal [4];
      cmpVal = '{8'h12, 8'h34, 8'h20, 8'h00};
      clock = 1'b0;
      reset = 1'b1;
      regRead = 1'b0;
      regWrite = 1'b0;
      bdmAccess = 1'b0;
      regIndex = 4'h0;
      regWriteData = 8'h00;
      triggerModeCode = 4'h9;
      beginTrace = 1'b0;
      executionQualifiedTrigger = 1'b0;
      chipSecure = 1'b0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++) expectReg("reset value", 4'(i), 8'h00);
      expectReg("control reset", IDX_CONTROL, 8'h00);
      `CHK("count reset", 4'h0, traceValidCount)
      $display("test reset values done");

      wr(IDX_FORCE_RESET, 8'h01, 1'b0);
      #1 `CHK("user force reset", 1'b0, systemResetRequest)
      wr(IDX_FORCE_RESET, 8'h01, 1'b1);
      #1 `CHK("bdm force reset", 1'b1, systemResetRequest)
      @(posedge clock);
      #1 `CHK("force reset pulse", 1'b0, systemResetRequest)
      expectReg("force reset read", IDX_FORCE_RESET, 8'h00);
      $display("test force reset done");

      for (int i = 0; i < 4; i++) wr(4'(i + 1), cmpVal[i], 1'b0);
      for (int i = 0; i < 4; i++) expectReg("comparator", 4'(i + 1), cmpVal[i]);
      wr(IDX_CONTROL, 8'h2F, 1'b0);
      expectReg("control rw", IDX_CONTROL, 8'h2F);
      @(posedge clock);
      chipSecure <= 1'b1;
      wr(IDX_CONTROL, 8'hC0, 1'b0);
      expectReg("secure enable", IDX_CONTROL, 8'h00);
      `CHK("secure arm", 1'b0, runActiveFlag)
      @(posedge clock);
      chipSecure <= 1'b0;
      wr(IDX_CONTROL, 8'hC0, 1'b0);
      #1 `CHK("arm", 1'b1, runActiveFlag)
      wr(IDX_CONTROL, 8'h80, 1'b0);
      #1 `CHK("manual stop", 1'b0, runActiveFlag)
      $display("test registers done");

      @(posedge clock);
      triggerModeCode <= TRG_A_ONLY;
      wr(IDX_CONTROL, 8'hD4, 1'b0);
      #1 `CHK("run count", 4'h0, traceValidCount)
      wr(IDX_CMP_A_HIGH, 8'h55, 1'b0);
      expectReg("armed cmp write", IDX_CMP_A_HIGH, 8'h12);
      for (int i = 1; i <= 10; i++) cpu.busCycle(16'h0100 + 16'(i), 1'b1, 1'b1, 8'h00);
      cpu.busCycle(16'h1234, 1'b1, 1'b0, 8'h00);
      waitBreak(seen, tagSeen);
      `CHK("read ignored", 1'b0, seen)
      cpu.busCycle(16'h1234, 1'b0, 1'b0, 8'h77);
      waitBreak(seen, tagSeen);
      `CHK("end trace break", 1'b1, seen)
      `CHK("force type", 1'b0, tagSeen)
      `CHK("run ended", 1'b0, runActiveFlag)
      `CHK("full count", 4'h8, traceValidCount)
      wr(IDX_FIFO_HIGH, 8'hEE, 1'b0);
      wr(IDX_FIFO_LOW, 8'hEE, 1'b0);
      for (int i = 0; i < 9; i++) begin
         w = (i < 8) ? 16'h0103 + 16'(i) : 16'h010A;
         expectReg("trace high", IDX_FIFO_HIGH, w[15:8]);
         expectReg("trace high again", IDX_FIFO_HIGH, w[15:8]);
         expectReg("trace low", IDX_FIFO_LOW, w[7:0]);
      end
      $display("test end trace done");

      @(posedge clock);
      triggerModeCode <= TRG_EVENT_B;
      wr(IDX_CONTROL, 8'hF3, 1'b0);
      cpu.busCycle(16'h2000, 1'b0, 1'b0, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         cpu.busCycle(16'h2000, 1'b1, 1'b0, 8'hA0 + 8'(i));
         if (i == 2) begin
            rd(IDX_FIFO_LOW, w[7:0]);
            rd(IDX_FIFO_LOW, w[7:0]);
         end
      end
      waitBreak(seen, tagSeen);
      `CHK("begin trace break", 1'b1, seen)
      `CHK("tag type", 1'b1, tagSeen)
      `CHK("event run ended", 1'b0, runActiveFlag)
      `CHK("event count", 4'h8, traceValidCount)
      expectReg("event high", IDX_FIFO_HIGH, 8'h00);
      for (int i = 0; i < 8; i++) begin
         expectReg("event low", IDX_FIFO_LOW, 8'hA0 + 8'(i));
      end
      $display("test event only done");

      @(posedge clock);
      triggerModeCode <= TRG_A_ONLY;
      beginTrace <= 1'b1;
      executionQualifiedTrigger <= 1'b1;
      wr(IDX_CONTROL, 8'hD0, 1'b0);
      cpu.busCycle(16'h0300, 1'b1, 1'b1, 8'h00);
      cpu.busCycle(16'h1234, 1'b0, 1'b0, 8'h00);
      waitBreak(seen, tagSeen);
      `CHK("plain access ignored", 1'b0, seen)
      `CHK("waiting run", 1'b1, runActiveFlag)
      `CHK("wait count", 4'h0, traceValidCount)
      cpu.execCycle(16'h1234);
      for (int i = 1; i <= 8; i++) cpu.busCycle(16'h0200 + 16'(i), 1'b1, 1'b1, 8'h00);
      waitBreak(seen, tagSeen);
      `CHK("begin trace break", 1'b1, seen)
      `CHK("begin force type", 1'b0, tagSeen)
      `CHK("begin run ended", 1'b0, runActiveFlag)
      `CHK("begin count", 4'h8, traceValidCount)
      for (int i = 1; i <= 8; i++) begin
         expectReg("begin high", IDX_FIFO_HIGH, 8'h02);
         expectReg("begin low", IDX_FIFO_LOW, 8'(i));
      end
      $display("test begin trace done");
      reportAndStop();
   end
endmodule
`default_nettype wire
